// ---- common/tpis_pkg.sv ----
// Types for the touch panel I2C register slave.
package tpis_pkg;
   typedef enum logic [2:0] {
      TPIS_IDLE  = 3'b000,
      TPIS_ADDR  = 3'b001,
      TPIS_RXB   = 3'b010,
      TPIS_TXB   = 3'b011,
      TPIS_ACK   = 3'b100,
      TPIS_RACK  = 3'b101
   } tpis_state_t;

   typedef struct packed {
      logic        we;
      logic [15:0] addr;
      logic [7:0]  data;
   } tpis_wr_t;
endpackage : tpis_pkg

// ---- common/tpis_regs.svh ----
// Constants for the touch panel I2C register slave.
`ifndef TPIS_REGS_SVH
`define TPIS_REGS_SVH
`define TPIS_DEV_ADDR      7'h5D
`define TPIS_WR_BYTE       8'hBA
`define TPIS_RD_BYTE       8'hBB
`define TPIS_EOS_ADDR      16'h8000
`define TPIS_BITS_PER_BYTE 4'h8
`endif

// ---- tb/tpis_host.sv ----
// Host model that masters the bus clock and data lines.
`timescale 1ns/10ps
`default_nettype none
module tpis_host (
   // Clock.
   input  wire logic ref_clk_i,
   // Bus pins, data released while high.
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : tick
   // Data moves only in the low phase, so a late change is never seen as a condition.
   task automatic put_bit(input logic b, output logic r);
      tick(4);
      sda_o <= b;
      tick(4);
      scl_o <= 1'b1;
      tick(6);
      r = sda_i;
      tick(2);
      scl_o <= 1'b0;
   endtask : put_bit
   task automatic start_cond;
      tick(4);
      sda_o <= 1'b1;
      tick(4);
      scl_o <= 1'b1;
      tick(8);
      sda_o <= 1'b0;
      tick(8);
      scl_o <= 1'b0;
   endtask : start_cond
   task automatic stop_cond;
      tick(4);
      sda_o <= 1'b0;
      tick(4);
      scl_o <= 1'b1;
      tick(8);
      sda_o <= 1'b1;
      tick(8);
   endtask : stop_cond
   task automatic put_byte(input logic [7:0] tx, input logic ack_i, output logic [7:0] rx,
                           output logic ack_o);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put_bit(tx[i], r);
         rx = {rx[6:0], r};
      end
      put_bit(ack_i, ack_o);
   endtask : put_byte
endmodule : tpis_host
`default_nettype wire

// ---- tb/tpis_slave_test.sv ----
// Self-checking bench for the touch panel I2C register slave.
`timescale 1ns/10ps
`default_nettype none
`include "tpis_regs.svh"
module tpis_slave_test;
   logic               ref_clk_i;
   logic               resetn_i;
   logic               scl;
   logic               host_sda;
   logic               sda_o;
   logic               sda_oe_o;
   logic               sda_wire;
   tpis_pkg::tpis_wr_t wr_o;
   logic [15:0]        rd_addr_o;
   logic [7:0]         rd_data_i;
   logic               refresh_o;
   int                 n_mismatch;
   int                 n_tests;
   int                 cycles;
   int                 n_refresh;
   int                 n_oe;
   int                 seed;
   tpis_pkg::tpis_wr_t wr_q[$];
   // Open drain with pull-up: any party pulling low wins.
   assign sda_wire = host_sda & ((sda_oe_o === 1'b1) ? sda_o : 1'b1);
   function automatic logic [7:0] mem(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction : mem
   assign rd_data_i = mem(rd_addr_o);
   tpis_slave dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_wire),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wr_o(wr_o), .rd_addr_o(rd_addr_o),
      .rd_data_i(rd_data_i), .refresh_o(refresh_o));
   tpis_host host (.ref_clk_i(ref_clk_i), .sda_i(sda_wire), .scl_o(scl), .sda_o(host_sda));
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   task automatic stop_test;
      if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk_val
   always @(posedge ref_clk_i) begin
      cycles++;
      if (wr_o.we === 1'b1) wr_q.push_back(wr_o);
      if (refresh_o === 1'b1) n_refresh++;
      if (sda_oe_o === 1'b1) n_oe++;
      if (cycles == 60000) begin
         n_mismatch++;
         stop_test();
      end
   end
   // Pointer write, n data bytes, then optionally a repeated start and rd_n read bytes.
   task automatic txn(input logic [7:0] dev, input logic [15:0] ptr, input int n, input int rd_n);
      logic [7:0]  rx;
      logic [7:0]  d;
      logic        ack;
      logic        nak;
      logic [15:0] e;
      nak = (dev !== `TPIS_WR_BYTE);
      n_refresh = 0;
      n_oe = 0;
      wr_q.delete();
      host.start_cond();
      host.put_byte(dev, 1'b1, rx, ack);
      chk_val(ack, nak, "address ack");
      if (nak == 1'b0) begin
         host.put_byte(ptr[15:8], 1'b1, rx, ack);
         chk_val(ack, 1'b0, "ptr high ack");
         host.put_byte(ptr[7:0], 1'b1, rx, ack);
         chk_val(ack, 1'b0, "ptr low ack");
         for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            host.put_byte(d, 1'b1, rx, ack);
            chk_val(ack, 1'b0, "data ack");
            chk_val(wr_q.size(), 1, "write count");
            e = ptr + 16'(i);
            if (wr_q.size() > 0) chk_val(wr_q.pop_front(), {1'b1, e, d}, "write");
         end
         if (rd_n > 0) begin
            host.start_cond();
            host.put_byte(`TPIS_RD_BYTE, 1'b1, rx, ack);
            chk_val(ack, 1'b0, "read address ack");
            for (int i = 0; i < rd_n; i++) begin
               host.put_byte(8'hFF, (i == rd_n - 1), rx, ack);
               e = ptr + 16'(n) + 16'(i);
               chk_val(rx, mem(e), "read data");
            end
         end
      end
      chk_val(n_refresh, 0, "refresh in traffic");
      host.stop_cond();
      host.tick(10);
      e = ptr + 16'(n);
      if (nak == 1'b0 && rd_n == 0) chk_val(rd_addr_o, e, "pointer");
      if (nak == 1'b1) chk_val(n_oe, 0, "drive on foreign address");
      chk_val(wr_q.size(), 0, "stray write");
      chk_val(n_refresh, (nak == 1'b0 && ptr == `TPIS_EOS_ADDR && n == 0 && rd_n == 0),
              "refresh");
   endtask : txn
   initial begin
      logic [6:0] a7;
      seed = 32'h9DFC;
      resetn_i = 1'b0;
      n_mismatch = 0;
      n_tests = 0;
      cycles = 0;
      repeat (10) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      txn(`TPIS_WR_BYTE, 16'h1234, 1, 0);
      txn(`TPIS_WR_BYTE, 16'hFFFF, 2, 0);
      txn(`TPIS_WR_BYTE, `TPIS_EOS_ADDR, 0, 0);
      txn(`TPIS_WR_BYTE, `TPIS_EOS_ADDR, 1, 0);
      txn(`TPIS_WR_BYTE, 16'h7FFF, 1, 0);
      txn(`TPIS_WR_BYTE, 16'h0F40, 0, 4);
      txn(`TPIS_WR_BYTE, 16'h0F40, 2, 3);
      txn(8'hBC, 16'h0000, 0, 0);
      for (int k = 0; k < 8; k++) begin
         a7 = 7'($random(seed));
         if (a7 == `TPIS_DEV_ADDR) a7 = 7'h5C;
         if (($random(seed) & 3) == 0) txn({a7, 1'b0}, 16'h0000, 0, 0);
         else txn(`TPIS_WR_BYTE, 16'($random(seed)), $random(seed) & 3, k & 1 ? 3 : 0);
      end
      txn(`TPIS_WR_BYTE, `TPIS_EOS_ADDR, 0, 0);
      stop_test();
   end
endmodule : tpis_slave_test
`default_nettype wire

// ---- verilog/tpis_slave.sv ----
// I2C target that gives a host access to a 16-bit addressed byte register space.
`timescale 1ns/10ps
`default_nettype none
`include "tpis_regs.svh"

module tpis_slave (
   // Clock and reset.
   input  wire logic              ref_clk_i,
   input  wire logic              resetn_i,
   // Bus pins.
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe_o,
   // Register space.
   output tpis_pkg::tpis_wr_t     wr_o,
   output logic [15:0]            rd_addr_o,
   input  wire logic [7:0]        rd_data_i,
   // Coordinate refresh release.
   output logic                   refresh_o
);

   logic [1:0]            scl_s_q;
   logic [1:0]            sda_s_q;
   logic                  scl_q;
   logic                  sda_q;
   tpis_pkg::tpis_state_t state_q;
   logic [3:0]            bit_q;
   logic [7:0]            sh_q;
   logic                  rd_q;
   logic [1:0]            phase_q;
   logic [15:0]           ptr_q;
   logic                  eos_q;
   logic                  ackd_q;

   // Two flops per pin keep the sampled levels free of metastability.
   // The bus rate only has to stay far below the reference clock.
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_i};
         sda_s_q <= {sda_s_q[0], sda_i};
         scl_q   <= scl_s_q[1];
         sda_q   <= sda_s_q[1];
      end
   end

   wire scl_rise = scl_s_q[1] & ~scl_q;
   wire scl_fall = ~scl_s_q[1] & scl_q;
   wire start_ev = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
   wire stop_ev  = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
   wire [7:0] rx_byte = {sh_q[6:0], sda_s_q[1]};
   wire addr_ok  = (sh_q[7:1] == `TPIS_DEV_ADDR);

   // Bits are taken on the rising clock edge, driven after the falling one.
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         state_q <= tpis_pkg::TPIS_IDLE;
         bit_q   <= 4'h0;
         sh_q    <= 8'h00;
         rd_q    <= 1'b0;
         phase_q <= 2'h0;
         ptr_q   <= 16'h0000;
         ackd_q  <= 1'b0;
      end else if (start_ev) begin
         state_q <= tpis_pkg::TPIS_ADDR;
         bit_q   <= 4'h0;
         phase_q <= 2'h0;
      end else if (stop_ev) begin
         state_q <= tpis_pkg::TPIS_IDLE;
      end else begin
         case (state_q)
            tpis_pkg::TPIS_ADDR, tpis_pkg::TPIS_RXB: begin
               if (scl_rise) begin
                  sh_q  <= rx_byte;
                  bit_q <= bit_q + 4'h1;
               end
               if (scl_fall && bit_q == `TPIS_BITS_PER_BYTE) begin
                  bit_q <= 4'h0;
                  if (state_q == tpis_pkg::TPIS_ADDR) begin
                     if (sh_q[7:1] == `TPIS_DEV_ADDR) begin
                        rd_q    <= sh_q[0];
                        ackd_q  <= 1'b1;
                        state_q <= tpis_pkg::TPIS_ACK;
                     end else begin
                        state_q <= tpis_pkg::TPIS_IDLE;
                     end
                  end else begin
                     ackd_q  <= 1'b1;
                     state_q <= tpis_pkg::TPIS_ACK;
                     case (phase_q)
                        2'h0: ptr_q[15:8] <= sh_q;
                        2'h1: ptr_q[7:0]  <= sh_q;
                        default: ptr_q    <= ptr_q + 16'h0001;
                     endcase
                     if (phase_q != 2'h2) begin
                        phase_q <= phase_q + 2'h1;
                     end
                  end
               end
            end
            tpis_pkg::TPIS_ACK: begin
               if (scl_fall) begin
                  ackd_q  <= 1'b0;
                  state_q <= rd_q ? tpis_pkg::TPIS_TXB : tpis_pkg::TPIS_RXB;
                  if (rd_q) begin
                     sh_q <= rd_data_i;
                  end
               end
            end
            tpis_pkg::TPIS_TXB: begin
               if (scl_fall) begin
                  bit_q <= bit_q + 4'h1;
                  sh_q  <= {sh_q[6:0], 1'b0};
                  if (bit_q == 4'h7) begin
                     bit_q   <= 4'h0;
                     state_q <= tpis_pkg::TPIS_RACK;
                  end
               end
            end
            tpis_pkg::TPIS_RACK: begin
               if (scl_rise) begin
                  ptr_q <= ptr_q + 16'h0001;
                  // A NACK ends the read; the host then sends stop.
                  state_q <= sda_s_q[1] ? tpis_pkg::TPIS_IDLE : tpis_pkg::TPIS_ACK;
               end
            end
            default: state_q <= tpis_pkg::TPIS_IDLE;
         endcase
      end
   end

   // Only data bytes reach the register space, so a bare pointer write stores nothing.
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         wr_o <= '0;
      end else begin
         wr_o.we <= 1'b0;
         if (state_q == tpis_pkg::TPIS_RXB && scl_fall && bit_q == `TPIS_BITS_PER_BYTE
             && phase_q == 2'h2 && !start_ev && !stop_ev) begin
            wr_o.we   <= 1'b1;
            wr_o.addr <= ptr_q;
            wr_o.data <= sh_q;
         end
      end
   end

   // End-of-session is armed by a bare write of its pointer and fires at stop.
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         eos_q     <= 1'b0;
         refresh_o <= 1'b0;
      end else begin
         refresh_o <= 1'b0;
         if (start_ev) begin
            eos_q <= 1'b0;
         end else if (stop_ev) begin
            eos_q     <= 1'b0;
            refresh_o <= eos_q;
         end else if (state_q == tpis_pkg::TPIS_RXB && scl_fall
                      && bit_q == `TPIS_BITS_PER_BYTE && phase_q == 2'h1) begin
            // Armed only by the pointer bytes, so a pointer reached by incrementing never arms.
            eos_q <= ({ptr_q[15:8], sh_q} == `TPIS_EOS_ADDR);
         end else if (wr_o.we) begin
            eos_q <= 1'b0;
         end
      end
   end

   // Output enable only in the ack slot or a driven zero of a read byte.
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         sda_o    <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         sda_o    <= 1'b0;
         // The host's own acknowledge slot of a read is never driven by us.
         sda_oe_o <= (state_q == tpis_pkg::TPIS_ACK && ackd_q) ||
                     (state_q == tpis_pkg::TPIS_TXB && !sh_q[7]);
      end
   end

   assign rd_addr_o = ptr_q;

   property p_ack_slot;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (state_q == tpis_pkg::TPIS_ACK && ackd_q) |=> sda_oe_o;
   endproperty
   a_ack_slot: assert property (p_ack_slot) else $error("ack not driven");

   property p_miss;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (state_q == tpis_pkg::TPIS_ADDR && scl_fall && bit_q == 4'h8 && !addr_ok && !start_ev
          && !stop_ev) |=> (state_q == tpis_pkg::TPIS_IDLE) ##1 !sda_oe_o;
   endproperty
   a_miss: assert property (p_miss) else $error("foreign address answered");

   property p_idle_quiet;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         $past(state_q) == tpis_pkg::TPIS_IDLE && state_q == tpis_pkg::TPIS_IDLE |-> !sda_oe_o;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle");

   property p_incr;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         wr_o.we |-> ##[1:2] (ptr_q == wr_o.addr + 16'h0001);
   endproperty
   a_incr: assert property (p_incr) else $error("pointer not advanced");

   property p_refresh;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         refresh_o |-> $past(stop_ev) && $past(eos_q);
   endproperty
   a_refresh: assert property (p_refresh) else $error("refresh without session end");

   property p_wr_phase;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         wr_o.we |-> phase_q == 2'h2;
   endproperty
   a_wr_phase: assert property (p_wr_phase) else $error("write before pointer");

   property p_bits;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         bit_q <= `TPIS_BITS_PER_BYTE;
   endproperty
   a_bits: assert property (p_bits) else $error("bit count overflow");

   property p_eos_arm;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         $rose(eos_q) |-> ptr_q == `TPIS_EOS_ADDR;
   endproperty
   a_eos_arm: assert property (p_eos_arm) else $error("session end on wrong pointer");

   sequence s_addr_done;
      state_q == tpis_pkg::TPIS_ADDR && scl_fall && bit_q == `TPIS_BITS_PER_BYTE
         && !start_ev && !stop_ev;
   endsequence

   sequence s_data_done;
      state_q == tpis_pkg::TPIS_RXB && scl_fall && bit_q == `TPIS_BITS_PER_BYTE
         && phase_q == 2'h2 && !start_ev && !stop_ev;
   endsequence

   property p_hit;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         s_addr_done ##0 addr_ok |=> (state_q == tpis_pkg::TPIS_ACK) ##1 sda_oe_o;
   endproperty
   a_hit: assert property (p_hit) else $error("own address not acknowledged");

   property p_wr_data;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         s_data_done |=> wr_o.we && (wr_o.data == $past(sh_q));
   endproperty
   a_wr_data: assert property (p_wr_data) else $error("data byte not written");

   property p_nack_end;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (state_q == tpis_pkg::TPIS_RACK && scl_rise && sda_s_q[1] && !start_ev && !stop_ev)
         |=> state_q == tpis_pkg::TPIS_IDLE;
   endproperty
   a_nack_end: assert property (p_nack_end) else $error("read went on after nack");

   property p_start_addr;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         start_ev |=> (state_q == tpis_pkg::TPIS_ADDR) && (bit_q == 4'h0);
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("start not taken");

   property p_stop_idle;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         stop_ev |=> state_q == tpis_pkg::TPIS_IDLE;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");

   // The drive may only move while the clock is low, or when a condition reset the state.
   property p_oe_edge;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         $changed(sda_oe_o) |-> !scl_q || $past(start_ev) || $past(stop_ev);
   endproperty
   a_oe_edge: assert property (p_oe_edge) else $error("data moved while clock high");

   property p_oe_low;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         sda_oe_o |-> !sda_o;
   endproperty
   a_oe_low: assert property (p_oe_low) else $error("driven level not low");

endmodule : tpis_slave
`default_nettype wire
